// file: aoom_object_map.v
// object dictionary and output path of the four-channel analog output module
// assumes the bus state and slot number come from the system module on this clock
`timescale 1ns/1ps
`include "aoom_regs.vh"
module aoom_object_map #(
	parameter CHANNELS = 4,
	parameter FIFO_DEPTH = 16
) (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// system module
	input wire [1:0] busState,
	input wire [3:0] mySlot,
	input wire sysEnable,
	// cyclic process data
	input wire pdValid,
	input wire [15:0] pdIndex,
	input wire [7:0] pdSub,
	input wire [15:0] pdData,
	output reg pdAccept,
	output reg pdReady,
	// acyclic object access
	input wire objReq,
	input wire objWrite,
	input wire [15:0] objIndex,
	input wire [7:0] objSub,
	input wire [7:0] objWdata,
	output reg objAck,
	output reg objErr,
	output reg [7:0] objRdata,
	// converter
	output reg dacSclk,
	output reg dacData,
	output reg dacLoad,
	output reg [7:0] slotSelect,
	output reg [47:0] rangeCodes
);
	localparam ST_IDLE = 2'h0;
	localparam ST_SEND = 2'h1;

	reg [11:0] rawCode_reg [0:CHANNELS-1];
	reg [7:0] range_reg [0:CHANNELS-1];
	reg [7:0] cal_reg [0:CHANNELS*3-1];
	reg [7:0] div_reg;
	reg bitEn_reg;
	reg [1:0] chSel_reg;
	reg [13:0] pendWord;
	reg pendValid;
	wire fifoReady;
	wire fifoOutValid;
	wire [13:0] fifoOutData;
	wire dacReady;
	wire dacSclkW;
	wire dacDataW;
	wire dacLoadW;

	wire isPreop = (busState == `AOOM_STATE_PREOP);
	wire isOp = (busState == `AOOM_STATE_OP);
	wire [15:0] outIndex = `AOOM_IDX_OUT_BASE | {8'h00, mySlot, 4'h0};
	wire pdHit = pdValid && isOp && (pdIndex == outIndex)
		&& (pdSub >= 8'h01) && (pdSub <= CHANNELS[7:0]);
	wire pdCodeOk = (pdData[15:12] == 4'h0);
	wire [1:0] pdCh = pdSub[1:0] - 2'h1;
	wire slotMatch = (slotSelect[3:0] == mySlot) && (slotSelect[7:4] == 4'h0);
	wire chHit = (objIndex[15:2] == `AOOM_IDX_CH_BASE >> 2);
	wire [1:0] objCh = objIndex[1:0];
	wire rangeOk = (objWdata >= `AOOM_RANGE_0_20MA) && (objWdata <= `AOOM_RANGE_0_10V);
	wire isCal = (objSub >= `AOOM_SUB_CAL_FIRST) && (objSub <= `AOOM_SUB_CAL_LAST);
	wire [3:0] calIdx = {2'h0, objCh} * 4'h3 + objSub[3:0] - 4'h3;

	// new codes queued toward the converter
	always @(posedge core_clk) begin
		if (rst) begin
			pendValid <= 1'b0;
			pendWord <= 14'h0000;
			pdAccept <= 1'b0;
			pdReady <= 1'b0;
		end else begin
			pdReady <= fifoReady && !pendValid;
			pdAccept <= 1'b0;
			if (pendValid && fifoReady) begin
				pendValid <= 1'b0;
			end
			if (pdHit && pdCodeOk && !pendValid) begin
				pendWord <= {pdCh, pdData[11:0]};
				pendValid <= 1'b1;
				pdAccept <= 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1) begin : gch
			always @(posedge core_clk) begin
				if (rst) begin
					rawCode_reg[g] <= 12'h000;
					range_reg[g] <= `AOOM_RANGE_RESET;
					cal_reg[g*3] <= 8'h00;
					cal_reg[g*3+1] <= 8'h00;
					cal_reg[g*3+2] <= 8'h00;
				end else begin
					if (pdHit && pdCodeOk && !pendValid && pdCh == g) begin
						rawCode_reg[g] <= pdData[11:0];
					end
					if (objReq && objWrite && chHit && slotMatch && isPreop && objCh == g) begin
						if (objSub == `AOOM_SUB_RANGE && rangeOk) begin
							range_reg[g] <= objWdata;
						end
						if (isCal && calIdx == g*3) begin
							cal_reg[g*3] <= objWdata;
						end
						if (isCal && calIdx == g*3+1) begin
							cal_reg[g*3+1] <= objWdata;
						end
						if (isCal && calIdx == g*3+2) begin
							cal_reg[g*3+2] <= objWdata;
						end
					end
				end
			end
			always @(posedge core_clk) begin
				if (rst) begin
					rangeCodes[g*8 +: 8] <= `AOOM_RANGE_RESET;
				end else begin
					rangeCodes[g*8 +: 8] <= range_reg[g];
				end
			end
		end
	endgenerate

	// unused upper range bytes read as zero
	always @(posedge core_clk) begin
		rangeCodes[47:32] <= 16'h0000;
	end

	// object access: one answer per request, next cycle
	always @(posedge core_clk) begin
		if (rst) begin
			slotSelect <= `AOOM_SLOT_RESET;
			objAck <= 1'b0;
			objErr <= 1'b0;
			objRdata <= 8'h00;
		end else begin
			objAck <= objReq;
			objErr <= 1'b0;
			objRdata <= 8'h00;
			if (objReq) begin
				if (objIndex == `AOOM_IDX_SLOT_SEL && objSub == `AOOM_SUB_SLOT) begin
					if (objWrite) begin
						if (objWdata <= `AOOM_SLOT_MAX) begin
							slotSelect <= objWdata;
						end else begin
							objErr <= 1'b1;
						end
					end else begin
						objRdata <= slotSelect;
					end
				end else if (chHit && slotMatch && (isPreop || isOp)) begin
					if (objSub == `AOOM_SUB_RAW) begin
						if (objWrite) begin
							objErr <= 1'b1;
						end else begin
							objRdata <= rawCode_reg[objCh][7:0];
						end
					end else if (objSub == `AOOM_SUB_RANGE) begin
						if (objWrite && (!isPreop || !rangeOk)) begin
							objErr <= 1'b1;
						end else if (!objWrite) begin
							objRdata <= range_reg[objCh];
						end
					end else if (isCal) begin
						if (objWrite && !isPreop) begin
							objErr <= 1'b1;
						end else if (!objWrite) begin
							objRdata <= cal_reg[calIdx];
						end
					end else begin
						objErr <= 1'b1;
					end
				end else begin
					objErr <= 1'b1;
				end
			end
		end
	end

	// converter bit-rate divider
	always @(posedge core_clk) begin
		if (rst) begin
			div_reg <= 8'h00;
			bitEn_reg <= 1'b0;
		end else begin
			bitEn_reg <= (div_reg == `AOOM_DAC_DIV - 8'h01);
			if (div_reg == `AOOM_DAC_DIV - 8'h01) begin
				div_reg <= 8'h00;
			end else begin
				div_reg <= div_reg + 8'h01;
			end
		end
	end

	aoom_fifo #(
		.WIDTH(14),
		.DEPTH(FIFO_DEPTH),
		.AW(4)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(pendValid),
		.inReady(fifoReady),
		.inData(pendWord),
		.outValid(fifoOutValid),
		.outReady(dacReady && sysEnable),
		.outData(fifoOutData)
	);

	aoom_dac_shift u_dac (
		.core_clk(core_clk),
		.rst(rst),
		.bitEn(bitEn_reg),
		.wordValid(fifoOutValid && sysEnable),
		.wordReady(dacReady),
		.wordData({fifoOutData[13:12], 2'h0, fifoOutData[11:0]}),
		.dacSclk(dacSclkW),
		.dacData(dacDataW),
		.dacLoad(dacLoadW)
	);

	always @(posedge core_clk) begin
		if (rst) begin
			dacSclk <= 1'b0;
			dacData <= 1'b0;
			dacLoad <= 1'b0;
		end else begin
			dacSclk <= dacSclkW;
			dacData <= dacDataW;
			dacLoad <= dacLoadW;
		end
	end
endmodule

// file: aoom_regs.vh
// object dictionary constants for the four-channel analog output module
// assumes an object access port (index, sub-entry, data) and a process data port
`ifndef AOOM_REGS_VH
`define AOOM_REGS_VH
`define AOOM_IDX_SLOT_SEL 16'h217f
`define AOOM_IDX_CH_BASE 16'h2180
`define AOOM_IDX_OUT_BASE 16'h7000
`define AOOM_SUB_SLOT 8'h01
`define AOOM_SUB_RAW 8'h01
`define AOOM_SUB_RANGE 8'h02
`define AOOM_SUB_CAL_FIRST 8'h03
`define AOOM_SUB_CAL_LAST 8'h05
`define AOOM_RANGE_0_20MA 8'h30
`define AOOM_RANGE_4_20MA 8'h31
`define AOOM_RANGE_0_10V 8'h32
`define AOOM_RANGE_RESET 8'h30
`define AOOM_SLOT_RESET 8'h00
`define AOOM_SLOT_MAX 8'h07
`define AOOM_CODE_MAX 12'hfff
`define AOOM_STATE_PREOP 2'h1
`define AOOM_STATE_OP 2'h2
`define AOOM_DAC_DIV 8'h10
`endif

// file: aoom_fifo.v
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module aoom_fifo #(
	parameter WIDTH = 14,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// fill side
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	// drain side
	output reg outValid,
	input wire outReady,
	output reg [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_reg;
	reg [AW-1:0] rdPtr_reg;
	reg [AW:0] count_reg;
	wire doWrite;
	wire doRead;
	wire canLoad;
	assign inReady = (count_reg != DEPTH[AW:0]);
	assign canLoad = !outValid || outReady;
	assign doWrite = inValid && inReady;
	assign doRead = canLoad && (count_reg != {(AW+1){1'b0}});
	always @(posedge core_clk) begin
		if (doWrite) begin
			mem[wrPtr_reg] <= inData;
		end
	end
	always @(posedge core_clk) begin
		if (rst) begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			outValid <= 1'b0;
			outData <= {WIDTH{1'b0}};
		end else begin
			if (doWrite) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (doRead) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
				outData <= mem[rdPtr_reg];
				outValid <= 1'b1;
			end else if (outReady) begin
				outValid <= 1'b0;
			end
			count_reg <= count_reg + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, doRead};
		end
	end
endmodule

// file: aoom_dac_shift.v
// serial shifter toward the d/a converter; one 16-bit frame per word
// assumes a one-cycle bit enable from the parent divider
`timescale 1ns/1ps
module aoom_dac_shift (
	// clock and reset
	input wire core_clk,
	input wire rst,
	// word in
	input wire bitEn,
	input wire wordValid,
	output reg wordReady,
	input wire [15:0] wordData,
	// converter pins
	output reg dacSclk,
	output reg dacData,
	output reg dacLoad
);
	reg [15:0] shift_reg;
	reg [4:0] bits_reg;
	reg busy_reg;
	always @(posedge core_clk) begin
		if (rst) begin
			shift_reg <= 16'h0000;
			bits_reg <= 5'h00;
			busy_reg <= 1'b0;
			wordReady <= 1'b0;
			dacSclk <= 1'b0;
			dacData <= 1'b0;
			dacLoad <= 1'b0;
		end else begin
			wordReady <= 1'b0;
			if (!busy_reg) begin
				dacLoad <= 1'b0;
				if (wordValid && !wordReady) begin
					shift_reg <= wordData;
					bits_reg <= 5'h10;
					busy_reg <= 1'b1;
					wordReady <= 1'b1;
				end
			end else if (bitEn) begin
				if (!dacSclk) begin
					dacData <= shift_reg[15];
					dacSclk <= 1'b1;
				end else begin
					dacSclk <= 1'b0;
					shift_reg <= {shift_reg[14:0], 1'b0};
					bits_reg <= bits_reg - 5'h01;
					if (bits_reg == 5'h01) begin
						busy_reg <= 1'b0;
						dacLoad <= 1'b1;
					end
				end
			end
		end
	end
endmodule

// file: aoom_chk.sv
// checker for the analog output object map
// bound to aoom_object_map; sees its ports only
`timescale 1ns/1ps
module aoom_chk (
	// clock and reset
	input logic core_clk,
	input logic rst,
	// system and process data
	input logic [1:0] busState,
	input logic [3:0] mySlot,
	input logic pdValid,
	input logic [15:0] pdIndex,
	input logic [7:0] pdSub,
	input logic [15:0] pdData,
	input logic pdAccept,
	// object access
	input logic objReq,
	input logic objWrite,
	input logic [15:0] objIndex,
	input logic [7:0] objSub,
	input logic [7:0] objWdata,
	input logic objAck,
	input logic objErr,
	input logic [7:0] objRdata,
	input logic [7:0] slotSelect,
	input logic [47:0] rangeCodes
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	function automatic bit okRange(input logic [7:0] c);
		return c >= 8'h30 && c <= 8'h32;
	endfunction
	sequence chWrite(s);
		objReq && objWrite && objIndex[15:2] == 14'h0860 && objSub == s;
	endsequence
	ack_follows_a: assert property (objReq |=> objAck) else $error("ack missing");
	ack_cause_a: assert property (objAck |-> $past(objReq)) else $error("stray ack");
	rdata_idle_a: assert property (!objAck |-> objRdata == 8'h00) else $error("rdata");
	pd_cause_a: assert property (pdAccept |-> $past(pdValid && busState == 2'h2
		&& pdData <= 16'h0fff && pdSub >= 8'h01 && pdSub <= 8'h04)) else $error("bad accept");
	pd_slot_a: assert property (pdAccept |-> $past(pdIndex) == {8'h70, mySlot, 4'h0})
		else $error("wrong index accepted");
	slot_max_a: assert property (slotSelect <= 8'h07) else $error("slot over 7");
	range_legal_a: assert property (okRange(rangeCodes[7:0]) && okRange(rangeCodes[15:8])
		&& okRange(rangeCodes[23:16]) && okRange(rangeCodes[31:24])) else $error("range");
	range_cause_a: assert property (!$stable(rangeCodes) && !$past(rst) |->
		$past(objAck && !objErr) && $past(busState, 2) == 2'h1) else $error("range change");
	bad_range_a: assert property (chWrite(8'h02) ##0 !okRange(objWdata) |=> objErr)
		else $error("bad range taken");
	cal_state_a: assert property (chWrite(8'h03) ##0 busState != 2'h1 |=> objErr)
		else $error("cal write outside pre-op");
endmodule
bind aoom_object_map aoom_chk chk (.core_clk, .rst, .busState, .mySlot, .pdValid, .pdIndex,
	.pdSub, .pdData, .pdAccept, .objReq, .objWrite, .objIndex, .objSub, .objWdata, .objAck,
	.objErr, .objRdata, .slotSelect, .rangeCodes);

// file: aoom_master_model.sv
// fieldbus master model: bus state and cyclic process data words
// drives the process data side of aoom_object_map on core_clk
`timescale 1ns/1ps
module aoom_master_model (
	// clock
	input logic core_clk,
	// bus state and process data
	output logic [1:0] busState,
	output logic pdValid,
	output logic [15:0] pdIndex,
	output logic [7:0] pdSub,
	output logic [15:0] pdData,
	input logic pdReady
);
	initial begin
		busState = 2'h0;
		pdValid = 1'b0;
		pdIndex = 16'h0000;
		pdSub = 8'h00;
		pdData = 16'h0000;
	end
	task automatic setState(input logic [1:0] s);
		@(posedge core_clk) busState <= s;
	endtask
	// one word; released lines show the inverse so stale data is never read
	task automatic send(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] d);
		int n;
		n = 0;
		while (pdReady !== 1'b1 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		@(posedge core_clk);
		pdValid <= 1'b1;
		pdIndex <= idx;
		pdSub <= sub;
		pdData <= d;
		@(posedge core_clk);
		pdValid <= 1'b0;
		pdIndex <= ~idx;
		pdSub <= ~sub;
		pdData <= ~d;
	endtask
endmodule

// file: tb.sv
// self-checking bench for aoom_object_map in slot 1
// object access driven here, process data through the master model
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic objReq = 1'b0;
	logic objWrite = 1'b0;
	logic [15:0] objIndex = 16'h0000;
	logic [7:0] objSub = 8'h00;
	logic [7:0] objWdata = 8'h00;
	logic sysEnable = 1'b0;
	logic sclkOld = 1'b0;
	logic [15:0] frameBits = 16'h0000;
	int loadCount = 0;
	logic [1:0] busState;
	logic pdValid, pdAccept, pdReady, objAck, objErr, dacSclk, dacData, dacLoad;
	logic [15:0] pdIndex, pdData;
	logic [7:0] pdSub, objRdata, slotSelect;
	logic [47:0] rangeCodes;
	int errCount = 0;
	int checkCount = 0;
	int n;
	always #4 core_clk = ~core_clk;
	aoom_master_model master (.core_clk, .busState, .pdValid, .pdIndex, .pdSub, .pdData,
		.pdReady);
	aoom_object_map uut (.core_clk, .rst, .busState, .mySlot(4'h1), .sysEnable,
		.pdValid, .pdIndex, .pdSub, .pdData, .pdAccept, .pdReady, .objReq, .objWrite,
		.objIndex, .objSub, .objWdata, .objAck, .objErr, .objRdata, .dacSclk, .dacData,
		.dacLoad, .slotSelect, .rangeCodes);
	// converter pins: collect bits on sclk rise, count load pulses
	always @(posedge core_clk) begin
		sclkOld <= dacSclk;
		if (dacSclk === 1'b1 && sclkOld === 1'b0)
			frameBits <= {frameBits[14:0], dacData};
		if (dacLoad === 1'b1)
			loadCount <= loadCount + 1;
	end
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic obj(input logic w, input logic [15:0] idx, input logic [7:0] sub,
		input logic [7:0] wd, input logic e, input logic [7:0] rd);
		@(posedge core_clk);
		objReq <= 1'b1;
		objWrite <= w;
		objIndex <= idx;
		objSub <= sub;
		objWdata <= wd;
		@(posedge core_clk);
		objReq <= 1'b0;
		#1;
		chk(objAck, 1'b1);
		chk(objErr, e);
		chk(objRdata, rd);
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] sub, wd, input logic e);
		obj(1'b1, idx, sub, wd, e, 8'h00);
	endtask
	task automatic rd(input logic [15:0] idx, input logic [7:0] sub, exp);
		obj(1'b0, idx, sub, 8'h00, 1'b0, exp);
	endtask
	task automatic tallyAndFinish;
		$display("checks %0d errors %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk(slotSelect, 8'h00);
		chk(rangeCodes, 48'h000030303030);
		master.setState(2'h1);
		wr(16'h217f, 8'h01, 8'h08, 1'b1);
		wr(16'h2180, 8'h03, 8'h5a, 1'b1);
		wr(16'h217f, 8'h01, 8'h01, 1'b0);
		rd(16'h217f, 8'h01, 8'h01);
		for (int i = 0; i < 4; i++)
			wr(16'h2180 + 16'(i), 8'h02, 8'(8'h30 + (i + 2) % 3), 1'b0);
		wr(16'h2181, 8'h02, 8'h33, 1'b1);
		@(posedge core_clk);
		#1;
		chk(rangeCodes, 48'h000032313032);
		rd(16'h2183, 8'h02, 8'h32);
		for (int s = 3; s < 6; s++) begin
			wr(16'h2182, 8'(s), 8'(8'ha0 + s), 1'b0);
			rd(16'h2182, 8'(s), 8'(8'ha0 + s));
		end
		wr(16'h2180, 8'h01, 8'h11, 1'b1);
		obj(1'b0, 16'h2184, 8'h01, 8'h00, 1'b1, 8'h00);
		chk(objErr, 1'b1);
		master.setState(2'h2);
		wr(16'h2181, 8'h02, 8'h30, 1'b1);
		wr(16'h2181, 8'h04, 8'h01, 1'b1);
		wr(16'h2181, 8'h03, 8'h01, 1'b1);
		chk(pdReady, 1'b1);
		for (int i = 0; i < 4; i++) begin
			master.send(16'h7010, 8'(i + 1), 16'h0fff - 16'(i) * 16'h0111);
			#1;
			chk(pdAccept, 1'b1);
			rd(16'h2180 + 16'(i), 8'h01, 8'hff - 8'(i) * 8'h11);
		end
		master.send(16'h7010, 8'h01, 16'h1000);
		#1;
		chk(pdAccept, 1'b0);
		master.send(16'h7000, 8'h01, 16'h0123);
		#1;
		chk(pdAccept, 1'b0);
		rd(16'h2180, 8'h01, 8'hff);
		repeat (600) @(posedge core_clk);
		sysEnable <= 1'b1;
		#1;
		chk(loadCount, 48'h0);
		n = 0;
		while (dacLoad !== 1'b1 && n < 2000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(dacLoad, 1'b1);
		chk(frameBits, 16'h0fff);
		tallyAndFinish;
	end
	initial begin
		#400000;
		errCount++;
		tallyAndFinish;
	end
endmodule
